// File: verilog/sfp_consts.vh
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SFP_ADDR_CFG1 8'h01
`define SFP_ADDR_CFG2 8'h02
`define SFP_ADDR_BW 8'h03
`define SFP_ADDR_PRE_HI 8'h04
`define SFP_ADDR_PRE_LO 8'h05
`define SFP_ADDR_PAYLEN 8'h06
`define SFP_ADDR_DWELL 8'h07
`define SFP_ADDR_HOPCH 8'h08
`define SFP_ADDR_FLAGS 8'h09
`define SFP_ADDR_MASK 8'h0A
`define SFP_ADDR_NSYM_HI 8'h0B
`define SFP_ADDR_NSYM_LO 8'h0C
`define SFP_ADDR_CMD 8'h0D
`define SFP_ADDR_STATUS 8'h0E

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SFP_CFG1_OMIT 0
`define SFP_CFG1_CRC 1
`define SFP_CFG1_CR_LSB 2
`define SFP_CFG2_DE 4
`define SFP_BW_LOWBAND 4
`define SFP_HOPCH_CRC 6
`define SFP_CMD_TX 0
`define SFP_CMD_RX 1
`define SFP_IRQ_HOP 0
`define SFP_IRQ_CRC 1
`define SFP_IRQ_HDR 2
`define SFP_IRQ_TXD 3
`define SFP_IRQ_RXD 4
`define SFP_IRQ_CFG 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SFP_RST_CFG1 8'h04
`define SFP_RST_CFG2 8'h07
`define SFP_RST_BW 8'h07
`define SFP_RST_PRE_HI 8'h00
`define SFP_RST_PRE_LO 8'h0C
`define SFP_RST_PAYLEN 8'h01
`define SFP_RST_DWELL 8'h00
`define SFP_RST_MASK 8'h00

// ----------------------------------------------------------------------
// timing and limits
// ----------------------------------------------------------------------
`define SFP_PRE_OVH_QTR 18'h00011
`define SFP_PRE_MIN 6
`define SFP_HDR_SYMS 16'h0008
`define SFP_HDR_CR 3'h4
`define SFP_SF_MIN 6
`define SFP_SF_MAX 12
`define SFP_BW_CODES 10
`define SFP_BW_HI_FIRST 8
`define SFP_BW0_DKHZ 78
`define SFP_BW1_DKHZ 104
`define SFP_BW2_DKHZ 156
`define SFP_BW3_DKHZ 208
`define SFP_BW4_DKHZ 312
`define SFP_BW5_DKHZ 417
`define SFP_BW6_DKHZ 625
`define SFP_BW7_DKHZ 1250
`define SFP_BW8_DKHZ 2500
`define SFP_BW9_DKHZ 5000

`endif

// File: verilog/sfp_framer.v
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "sfp_consts.vh"

module sfp_framer #(
    parameter CLK_KHZ = 250000
) (
    input wire clk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_r,
    input wire rx_preamble_det,
    input wire rx_header_ok,
    input wire rx_header_bad,
    input wire [7:0] rx_hdr_len,
    input wire [2:0] rx_hdr_cr,
    input wire rx_hdr_crc,
    input wire rx_payload_crc_bad,
    output reg irq_r,
    output reg tx_on_r,
    output reg rx_on_r,
    output reg seg_preamble_r,
    output reg seg_header_r,
    output reg seg_payload_r,
    output reg symbol_tick_r,
    output reg [5:0] hop_index_r,
    output reg [2:0] code_rate_r,
    output reg [7:0] hdr_len_r,
    output reg [2:0] hdr_cr_r,
    output reg hdr_crc_r,
    output reg crc_append_r
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam ST_IDLE = 7'h01;
    localparam ST_TPRE = 7'h02;
    localparam ST_THDR = 7'h04;
    localparam ST_TPAY = 7'h08;
    localparam ST_RSRCH = 7'h10;
    localparam ST_RHDR = 7'h20;
    localparam ST_RPAY = 7'h40;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [7:0] cfg1_r, cfg2_r, bw_r, pre_hi_r, pre_lo_r, paylen_r;
    reg [7:0] dwell_r, mask_r;
    reg [5:0] flags_r, flags_nxt;
    reg [6:0] state_r, state_nxt;
    reg [23:0] chip_cnt_r;
    reg [9:0] qchip_r;
    reg [1:0] qtr_r;
    reg [17:0] pre_cnt_r;
    reg [15:0] sym_cnt_r;
    reg [7:0] dwell_cnt_r;
    reg [5:0] hop_idx_r;
    reg crc_present_r;
    reg [7:0] rx_len_r;
    reg [2:0] rx_cr_r;
    reg rx_crc_r;
    reg tb_clr;
    reg [5:0] set_flags;
    reg hop_go;

    wire omit = cfg1_r[`SFP_CFG1_OMIT];
    wire crc_en = cfg1_r[`SFP_CFG1_CRC];
    wire [2:0] cfg_cr = cfg1_r[`SFP_CFG1_CR_LSB+2:`SFP_CFG1_CR_LSB];
    wire [3:0] sf = cfg2_r[3:0];
    wire de = cfg2_r[`SFP_CFG2_DE];
    wire [3:0] bw_code = bw_r[3:0];
    wire low_band = bw_r[`SFP_BW_LOWBAND];
    wire [15:0] pre_set = {pre_hi_r, pre_lo_r};
    wire cmd_wr = reg_wr && (reg_addr == `SFP_ADDR_CMD);
    wire tx_go = cmd_wr && reg_wdata[`SFP_CMD_TX];
    wire rx_go = cmd_wr && reg_wdata[`SFP_CMD_RX] && !reg_wdata[`SFP_CMD_TX];

    // ------------------------------------------------------------------
    // configuration check
    // ------------------------------------------------------------------
    wire sf_ok = (sf >= `SFP_SF_MIN) && (sf <= `SFP_SF_MAX);
    wire bw_ok = (bw_code < `SFP_BW_CODES) &&
        !(low_band && (bw_code >= `SFP_BW_HI_FIRST));
    wire hdr_ok = !((sf == `SFP_SF_MIN) && !omit);
    wire pre_ok = (pre_set >= `SFP_PRE_MIN);
    wire cr_ok = (cfg_cr >= 3'h1) && (cfg_cr <= `SFP_HDR_CR);
    wire cfg_ok = sf_ok && bw_ok && hdr_ok && pre_ok && cr_ok;

    // ------------------------------------------------------------------
    // symbol timebase
    // ------------------------------------------------------------------
    reg [23:0] chip_div;
    integer div_i;
    always @* begin
        case (bw_code)
            4'h0: div_i = CLK_KHZ * 10 / `SFP_BW0_DKHZ;
            4'h1: div_i = CLK_KHZ * 10 / `SFP_BW1_DKHZ;
            4'h2: div_i = CLK_KHZ * 10 / `SFP_BW2_DKHZ;
            4'h3: div_i = CLK_KHZ * 10 / `SFP_BW3_DKHZ;
            4'h4: div_i = CLK_KHZ * 10 / `SFP_BW4_DKHZ;
            4'h5: div_i = CLK_KHZ * 10 / `SFP_BW5_DKHZ;
            4'h6: div_i = CLK_KHZ * 10 / `SFP_BW6_DKHZ;
            4'h7: div_i = CLK_KHZ * 10 / `SFP_BW7_DKHZ;
            4'h8: div_i = CLK_KHZ * 10 / `SFP_BW8_DKHZ;
            default: div_i = CLK_KHZ * 10 / `SFP_BW9_DKHZ;
        endcase
        chip_div = div_i[23:0];
        if (chip_div == 24'h000000) begin
            chip_div = 24'h000001;
        end
    end

    // chips per quarter symbol is 2^(sf-2)
    wire [9:0] qchips = sf_ok ? (10'h001 << (sf - 4'h2)) : 10'h010;
    wire chip_end = (chip_cnt_r == chip_div - 24'h000001);
    wire qtick = chip_end && (qchip_r == qchips - 10'h001);
    wire stick = qtick && (qtr_r == 2'h3);

    // ------------------------------------------------------------------
    // payload symbol count
    // ------------------------------------------------------------------
    wire use_rx = (state_r == ST_RHDR || state_r == ST_RPAY) && !omit;
    wire [7:0] pl = use_rx ? rx_len_r : paylen_r;
    wire [2:0] cr_eff = use_rx ? rx_cr_r : cfg_cr;
    wire crc_eff = use_rx ? rx_crc_r : crc_en;
    reg [15:0] nsym;
    integer num, den, q, tot;
    always @* begin
        num = 8 * pl - 4 * sf + 28 + 16 * crc_eff - 20 * omit;
        den = 4 * (sf - 2 * de);
        if (den <= 0) begin
            den = 4;
        end
        if (num > 0) begin
            q = (num + den - 1) / den;
        end else begin
            q = 0;
        end
        tot = 8 + q * (cr_eff + 4);
        nsym = tot[15:0];
    end
    // symbols after the header section
    wire [15:0] pay_syms = omit ? nsym : nsym - `SFP_HDR_SYMS;
    // preamble in quarter symbols: 4n + 17
    wire [17:0] pre_total = {pre_set, 2'b00} + `SFP_PRE_OVH_QTR;

    // ------------------------------------------------------------------
    // framing state machine
    // ------------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        set_flags = 6'h00;
        tb_clr = 1'b0;
        hop_go = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (tx_go || rx_go) begin
                    tb_clr = 1'b1;
                    if (!cfg_ok) begin
                        set_flags[`SFP_IRQ_CFG] = 1'b1;
                    end else if (tx_go) begin
                        state_nxt = ST_TPRE;
                    end else begin
                        state_nxt = ST_RSRCH;
                    end
                end
            end
            ST_TPRE: begin
                if (qtick && pre_cnt_r == pre_total - 18'h00001) begin
                    tb_clr = 1'b1;
                    state_nxt = omit ? ST_TPAY : ST_THDR;
                end
            end
            ST_THDR: begin
                if (stick && sym_cnt_r == `SFP_HDR_SYMS - 1) begin
                    if (pay_syms == 16'h0000) begin
                        state_nxt = ST_IDLE;
                        set_flags[`SFP_IRQ_TXD] = 1'b1;
                    end else begin
                        state_nxt = ST_TPAY;
                    end
                end
            end
            ST_TPAY: begin
                hop_go = stick;
                if (stick && sym_cnt_r == pay_syms - 16'h0001) begin
                    state_nxt = ST_IDLE;
                    set_flags[`SFP_IRQ_TXD] = 1'b1;
                end
            end
            ST_RSRCH: begin
                if (rx_preamble_det) begin
                    tb_clr = 1'b1;
                    state_nxt = omit ? ST_RPAY : ST_RHDR;
                end
            end
            ST_RHDR: begin
                if (rx_header_bad) begin
                    set_flags[`SFP_IRQ_HDR] = 1'b1;
                    state_nxt = ST_RSRCH;
                end else if (rx_header_ok) begin
                    tb_clr = 1'b1;
                    state_nxt = ST_RPAY;
                end
            end
            ST_RPAY: begin
                hop_go = stick;
                if (rx_payload_crc_bad && crc_eff) begin
                    set_flags[`SFP_IRQ_CRC] = 1'b1;
                end
                if (stick && sym_cnt_r == pay_syms - 16'h0001) begin
                    state_nxt = ST_IDLE;
                    set_flags[`SFP_IRQ_RXD] = 1'b1;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (hop_go && dwell_r != 8'h00 && dwell_cnt_r == dwell_r - 8'h01) begin
            set_flags[`SFP_IRQ_HOP] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // flags: set wins over write-one clear
    // ------------------------------------------------------------------
    always @* begin
        flags_nxt = flags_r;
        if (reg_wr && reg_addr == `SFP_ADDR_FLAGS) begin
            flags_nxt = flags_r & ~reg_wdata[5:0];
        end
        flags_nxt = flags_nxt | set_flags;
    end

    // ------------------------------------------------------------------
    // sequential logic
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            cfg1_r <= `SFP_RST_CFG1;
            cfg2_r <= `SFP_RST_CFG2;
            bw_r <= `SFP_RST_BW;
            pre_hi_r <= `SFP_RST_PRE_HI;
            pre_lo_r <= `SFP_RST_PRE_LO;
            paylen_r <= `SFP_RST_PAYLEN;
            dwell_r <= `SFP_RST_DWELL;
            mask_r <= `SFP_RST_MASK;
            flags_r <= 6'h00;
            state_r <= ST_IDLE;
            chip_cnt_r <= 24'h000000;
            qchip_r <= 10'h000;
            qtr_r <= 2'h0;
            pre_cnt_r <= 18'h00000;
            sym_cnt_r <= 16'h0000;
            dwell_cnt_r <= 8'h00;
            hop_idx_r <= 6'h00;
            crc_present_r <= 1'b0;
            rx_len_r <= 8'h00;
            rx_cr_r <= 3'h0;
            rx_crc_r <= 1'b0;
            reg_rdata_r <= 8'h00;
        end else begin
            if (reg_wr) begin
                if (reg_addr == `SFP_ADDR_CFG1) begin
                    cfg1_r <= reg_wdata;
                end else if (reg_addr == `SFP_ADDR_CFG2) begin
                    cfg2_r <= reg_wdata;
                end else if (reg_addr == `SFP_ADDR_BW) begin
                    bw_r <= reg_wdata;
                end else if (reg_addr == `SFP_ADDR_PRE_HI) begin
                    pre_hi_r <= reg_wdata;
                end else if (reg_addr == `SFP_ADDR_PRE_LO) begin
                    pre_lo_r <= reg_wdata;
                end else if (reg_addr == `SFP_ADDR_PAYLEN) begin
                    paylen_r <= reg_wdata;
                end else if (reg_addr == `SFP_ADDR_DWELL) begin
                    dwell_r <= reg_wdata;
                end else if (reg_addr == `SFP_ADDR_MASK) begin
                    mask_r <= reg_wdata;
                end
            end
            flags_r <= flags_nxt;
            state_r <= state_nxt;
            // timebase
            if (tb_clr || qtick) begin
                chip_cnt_r <= 24'h000000;
                qchip_r <= 10'h000;
                qtr_r <= tb_clr ? 2'h0 : qtr_r + 2'h1;
            end else if (chip_end) begin
                chip_cnt_r <= 24'h000000;
                qchip_r <= qchip_r + 10'h001;
            end else begin
                chip_cnt_r <= chip_cnt_r + 24'h000001;
            end
            // preamble quarters and section symbols
            if (tb_clr) begin
                pre_cnt_r <= 18'h00000;
            end else if (qtick) begin
                pre_cnt_r <= pre_cnt_r + 18'h00001;
            end
            if (tb_clr || (state_nxt != state_r)) begin
                sym_cnt_r <= 16'h0000;
            end else if (stick) begin
                sym_cnt_r <= sym_cnt_r + 16'h0001;
            end
            // hop channel
            if (state_r == ST_IDLE || state_nxt == ST_RSRCH) begin
                hop_idx_r <= 6'h00;
                dwell_cnt_r <= 8'h00;
            end else if (hop_go && dwell_r != 8'h00) begin
                if (dwell_cnt_r == dwell_r - 8'h01) begin
                    dwell_cnt_r <= 8'h00;
                    hop_idx_r <= hop_idx_r + 6'h01;
                end else begin
                    dwell_cnt_r <= dwell_cnt_r + 8'h01;
                end
            end
            // received header fields
            if (state_r == ST_RHDR && rx_header_ok && !rx_header_bad) begin
                rx_len_r <= rx_hdr_len;
                rx_cr_r <= rx_hdr_cr;
                rx_crc_r <= rx_hdr_crc;
                crc_present_r <= rx_hdr_crc;
            end
            // read port
            if (reg_rd) begin
                if (reg_addr == `SFP_ADDR_CFG1) begin
                    reg_rdata_r <= cfg1_r;
                end else if (reg_addr == `SFP_ADDR_CFG2) begin
                    reg_rdata_r <= cfg2_r;
                end else if (reg_addr == `SFP_ADDR_BW) begin
                    reg_rdata_r <= bw_r;
                end else if (reg_addr == `SFP_ADDR_PRE_HI) begin
                    reg_rdata_r <= pre_hi_r;
                end else if (reg_addr == `SFP_ADDR_PRE_LO) begin
                    reg_rdata_r <= pre_lo_r;
                end else if (reg_addr == `SFP_ADDR_PAYLEN) begin
                    reg_rdata_r <= paylen_r;
                end else if (reg_addr == `SFP_ADDR_DWELL) begin
                    reg_rdata_r <= dwell_r;
                end else if (reg_addr == `SFP_ADDR_HOPCH) begin
                    reg_rdata_r <= {1'b0, crc_present_r, hop_idx_r};
                end else if (reg_addr == `SFP_ADDR_FLAGS) begin
                    reg_rdata_r <= {2'b00, flags_r};
                end else if (reg_addr == `SFP_ADDR_MASK) begin
                    reg_rdata_r <= mask_r;
                end else if (reg_addr == `SFP_ADDR_NSYM_HI) begin
                    reg_rdata_r <= nsym[15:8];
                end else if (reg_addr == `SFP_ADDR_NSYM_LO) begin
                    reg_rdata_r <= nsym[7:0];
                end else if (reg_addr == `SFP_ADDR_STATUS) begin
                    reg_rdata_r <= {1'b0, state_r};
                end else begin
                    reg_rdata_r <= 8'h00;
                end
            end else begin
                reg_rdata_r <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
            tx_on_r <= 1'b0;
            rx_on_r <= 1'b0;
            seg_preamble_r <= 1'b0;
            seg_header_r <= 1'b0;
            seg_payload_r <= 1'b0;
            symbol_tick_r <= 1'b0;
            hop_index_r <= 6'h00;
            code_rate_r <= 3'h0;
            hdr_len_r <= 8'h00;
            hdr_cr_r <= 3'h0;
            hdr_crc_r <= 1'b0;
            crc_append_r <= 1'b0;
        end else begin
            irq_r <= |(flags_r & ~mask_r[5:0]);
            tx_on_r <= (state_r == ST_TPRE) || (state_r == ST_THDR) ||
                (state_r == ST_TPAY);
            rx_on_r <= (state_r == ST_RSRCH) || (state_r == ST_RHDR) ||
                (state_r == ST_RPAY);
            seg_preamble_r <= (state_r == ST_TPRE);
            seg_header_r <= (state_r == ST_THDR) || (state_r == ST_RHDR);
            seg_payload_r <= (state_r == ST_TPAY) || (state_r == ST_RPAY);
            symbol_tick_r <= stick && (state_r != ST_IDLE) &&
                (state_r != ST_RSRCH);
            hop_index_r <= hop_idx_r;
            if (state_r == ST_THDR || state_r == ST_RHDR) begin
                code_rate_r <= `SFP_HDR_CR;
            end else begin
                code_rate_r <= cr_eff;
            end
            hdr_len_r <= paylen_r;
            hdr_cr_r <= cfg_cr;
            hdr_crc_r <= crc_en;
            crc_append_r <= crc_en;
        end
    end

endmodule // sfp_framer

// File: bench/sfp_framer_monitor.sv
`timescale 1ns/1ps
`include "sfp_consts.vh"
// ----------------------------------------------------------------------
// framing and hop checks
// ----------------------------------------------------------------------
module sfp_framer_monitor (
    input wire clk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_r,
    input wire rx_header_bad,
    input wire irq_r,
    input wire tx_on_r,
    input wire rx_on_r,
    input wire seg_preamble_r,
    input wire seg_header_r,
    input wire symbol_tick_r,
    input wire [5:0] hop_index_r,
    input wire [2:0] code_rate_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence hop_step;
        hop_index_r == $past(hop_index_r) + 6'h01;
    endsequence
    sequence tick_near;
        symbol_tick_r || $past(symbol_tick_r) || $past(symbol_tick_r, 2);
    endsequence
    AST_PRE_HDR_CH0: assert property (
        (seg_preamble_r || seg_header_r) |-> hop_index_r == 6'h00)
        else $error("hop index not zero before payload");
    AST_HDR_RATE: assert property (
        seg_header_r |-> code_rate_r == `SFP_HDR_CR)
        else $error("header not at strongest rate");
    AST_HOP_STEP: assert property (
        (hop_index_r != $past(hop_index_r) && hop_index_r != 6'h00)
        |-> hop_step)
        else $error("hop index jumped");
    AST_HOP_TICK: assert property (hop_step |-> tick_near)
        else $error("hop off symbol boundary");
    AST_TX_START: assert property (
        $rose(tx_on_r) |-> seg_preamble_r && $past(reg_wr, 2)
        && $past(reg_addr, 2) == `SFP_ADDR_CMD)
        else $error("transmit began wrongly");
    AST_HDR_BAD: assert property (
        (rx_on_r && seg_header_r && rx_header_bad)
        |-> ##2 !seg_header_r && hop_index_r == 6'h00)
        else $error("no return to channel zero");
    AST_IRQ_FALL: assert property (
        $fell(irq_r) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("irq dropped without a write");
    AST_RD_IDLE: assert property (
        !$past(reg_rd) |-> reg_rdata_r == 8'h00)
        else $error("read data outside read slot");
endmodule // sfp_framer_monitor

bind sfp_framer sfp_framer_monitor sfp_framer_monitor_i (.clk, .reset_n,
    .reg_addr, .reg_wr, .reg_rd, .reg_rdata_r, .rx_header_bad, .irq_r,
    .tx_on_r, .rx_on_r, .seg_preamble_r, .seg_header_r, .symbol_tick_r,
    .hop_index_r, .code_rate_r);

// File: bench/sfp_remote.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// far transmitter seen by the receive demodulator
// ----------------------------------------------------------------------
module sfp_remote #(
    parameter LAG = 5
) (
    input wire clk,
    input wire go,
    input wire bad,
    input wire seg_header_r,
    input wire seg_payload_r,
    output reg preamble_det,
    output reg header_ok,
    output reg header_bad,
    output reg [7:0] hdr_len,
    output reg [2:0] hdr_cr,
    output reg hdr_crc,
    output reg crc_bad
);
    initial begin
        {preamble_det, header_ok, header_bad, crc_bad} = 4'h0;
        {hdr_len, hdr_cr, hdr_crc} = 12'hFED;
    end
    always @(posedge clk) begin
        if (go) begin
            preamble_det <= 1'b1;
            @(posedge clk);
            preamble_det <= 1'b0;
            while (!seg_header_r) @(posedge clk);
            repeat (LAG) @(posedge clk);
            header_ok <= !bad;
            header_bad <= bad;
            {hdr_len, hdr_cr, hdr_crc} <= 12'h012;
            @(posedge clk);
            {header_ok, header_bad} <= 2'h0;
            {hdr_len, hdr_cr, hdr_crc} <= 12'hFED;
            if (!bad) begin
                while (!seg_payload_r) @(posedge clk);
                crc_bad <= 1'b1;
                @(posedge clk);
                crc_bad <= 1'b0;
            end
        end
    end
endmodule // sfp_remote

// File: bench/test_sfp_framer.sv
`timescale 1ns/1ps
`include "sfp_consts.vh"
module test_sfp_framer;
    reg clk, reset_n, reg_wr, reg_rd, go, bad;
    reg [7:0] reg_addr, reg_wdata;
    wire [7:0] reg_rdata_r, rx_hdr_len, hdr_len_r;
    wire [2:0] rx_hdr_cr, code_rate_r, hdr_cr_r;
    wire [5:0] hop_index_r;
    wire rx_preamble_det, rx_header_ok, rx_header_bad, rx_hdr_crc;
    wire rx_payload_crc_bad, irq_r, tx_on_r, rx_on_r, seg_preamble_r;
    wire seg_header_r, seg_payload_r, symbol_tick_r, hdr_crc_r, crc_append_r;
    integer failures, tests_run, i, pre_cnt, pay_cnt;
    reg [31:0] rows [0:9];
    sfp_framer #(.CLK_KHZ(250)) sfp_framer_i (.clk, .reset_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .rx_preamble_det,
        .rx_header_ok, .rx_header_bad, .rx_hdr_len, .rx_hdr_cr, .rx_hdr_crc,
        .rx_payload_crc_bad, .irq_r, .tx_on_r, .rx_on_r, .seg_preamble_r,
        .seg_header_r, .seg_payload_r, .symbol_tick_r, .hop_index_r,
        .code_rate_r, .hdr_len_r, .hdr_cr_r, .hdr_crc_r, .crc_append_r);
    sfp_remote sfp_remote_i (.clk, .go, .bad, .seg_header_r, .seg_payload_r,
        .preamble_det(rx_preamble_det), .header_ok(rx_header_ok),
        .header_bad(rx_header_bad), .hdr_len(rx_hdr_len),
        .hdr_cr(rx_hdr_cr), .hdr_crc(rx_hdr_crc), .crc_bad(rx_payload_crc_bad));
    // ------------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------------
    task check(input [7:0] s, input [7:0] e); begin
        tests_run = tests_run + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    end endtask
    task wr(input [7:0] a, input [7:0] d); begin
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    end endtask
    task rdc(input [7:0] a, input [7:0] m, input [7:0] e); begin
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata_r & m, e);
    end endtask
    task results; begin
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (reset_n) begin
            pre_cnt <= pre_cnt + seg_preamble_r;
            pay_cnt <= pay_cnt + seg_payload_r;
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures = failures + 1;
        results;
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {reset_n, reg_wr, reg_rd, go, bad} = 5'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        {failures, tests_run, pre_cnt, pay_cnt} = 128'h0;
        rows[0] = 32'h0000050C;
        rows[1] = 32'h00000104;
        rows[2] = 32'h00000A00;
        rows[3] = 32'h00000700;
        rows[4] = 32'h00000C0D;
        rows[5] = 32'h01120C10;
        rows[6] = 32'h06400CA0;
        rows[7] = 32'h021C0C70;
        rows[8] = 32'h3F553F00;
        rows[9] = 32'h0AFF0AFF;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 10; i = i + 1) begin
            wr(rows[i][31:24], rows[i][23:16]);
            rdc(rows[i][15:8], 8'hFF, rows[i][7:0]);
        end
        wr(`SFP_ADDR_CFG1, 8'h04);
        wr(`SFP_ADDR_CFG2, 8'h06);
        wr(`SFP_ADDR_MASK, 8'h00);
        wr(`SFP_ADDR_PAYLEN, 8'h01);
        wr(`SFP_ADDR_CMD, 8'h01);
        repeat (4) @(posedge clk);
        check({7'h00, tx_on_r}, 8'h00);
        rdc(`SFP_ADDR_FLAGS, 8'h20, 8'h20);
        wr(`SFP_ADDR_FLAGS, 8'h3F);
        wr(`SFP_ADDR_CFG1, 8'h07);
        wr(`SFP_ADDR_PRE_LO, 8'h06);
        wr(`SFP_ADDR_BW, 8'h18);
        wr(`SFP_ADDR_CMD, 8'h01);
        rdc(`SFP_ADDR_FLAGS, 8'h20, 8'h20);
        wr(`SFP_ADDR_FLAGS, 8'h3F);
        wr(`SFP_ADDR_BW, 8'h07);
        wr(`SFP_ADDR_DWELL, 8'h02);
        wr(`SFP_ADDR_CMD, 8'h01);
        wait (tx_on_r);
        check({7'h00, crc_append_r}, 8'h01);
        check(hdr_len_r, 8'h01);
        check({4'h0, hdr_crc_r, hdr_cr_r}, 8'h09);
        wait (hop_index_r == 6'h01);
        repeat (3) @(posedge clk);
        check({7'h00, irq_r}, 8'h01);
        rdc(`SFP_ADDR_FLAGS, 8'h01, 8'h01);
        wr(`SFP_ADDR_FLAGS, 8'h01);
        rdc(`SFP_ADDR_FLAGS, 8'h01, 8'h00);
        wr(`SFP_ADDR_MASK, 8'h01);
        wait (hop_index_r == 6'h02);
        repeat (3) @(posedge clk);
        check({7'h00, irq_r}, 8'h00);
        wait (!tx_on_r);
        @(posedge clk);
        check(pre_cnt[7:0], 8'h20);
        check(pre_cnt[15:8], 8'h05);
        check(pay_cnt[15:8], 8'h06);
        check(pay_cnt[7:0], 8'h80);
        rdc(`SFP_ADDR_FLAGS, 8'h08, 8'h08);
        wr(`SFP_ADDR_FLAGS, 8'h3F);
        wr(`SFP_ADDR_MASK, 8'h00);
        wr(`SFP_ADDR_CFG1, 8'h04);
        wr(`SFP_ADDR_CFG2, 8'h07);
        wr(`SFP_ADDR_DWELL, 8'h01);
        wr(`SFP_ADDR_CMD, 8'h02);
        wait (rx_on_r);
        for (i = 1; i >= 0; i = i - 1) begin
            @(posedge clk);
            bad <= i[0];
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            if (i == 1) begin
                wait (rx_header_bad);
                repeat (4) @(posedge clk);
                check({2'h0, hop_index_r}, 8'h00);
                rdc(`SFP_ADDR_FLAGS, 8'h04, 8'h04);
            end
        end
        wait (hop_index_r == 6'h01);
        check({7'h00, seg_payload_r}, 8'h01);
        wait (!rx_on_r);
        rdc(`SFP_ADDR_HOPCH, 8'h40, 8'h00);
        rdc(`SFP_ADDR_FLAGS, 8'h12, 8'h10);
        results;
    end
endmodule // test_sfp_framer
